// File: verilog/boot_lock_defs.svh
// address map, field positions, reset values and timing counts
`ifndef BOOT_LOCK_DEFS_SVH
`define BOOT_LOCK_DEFS_SVH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define LOCK_MODE_ADDR   32'hFFFF_E510
`define LOCK_KEY_ADDR    32'hFFFF_E514
`define FLASH_STAT_ADDR  32'hFFFF_E518
`define GEAR_STAT_ADDR   32'hFFFF_E51C

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define LOCK_KEY_VALUE   32'h0000_00C5
`define PROBE_DIS_BIT    0
`define PROBE_DIS_RST    1'h1
`define INHIBIT_RST      1'h1
`define AREA_MSB         3
`define AREA_LSB         0
`define AREA_LOCKED      4'hF
`define GEAR_MSB         1
`define GEAR_LSB         0
`define MODE_MSB         5
`define MODE_LSB         4
`define RUN_BIT          8
`define FULL_STRB        4'hF
`define ZERO_WORD        32'h0000_0000

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ          100
`define NORMAL_RST_CLKS  12
`define POR_US           60
`define FLASH_RST_NS     500
`define POR_CYCLES       (`POR_US * `CLK_MHZ)
`define FLASH_RST_CYCLES ((`FLASH_RST_NS * `CLK_MHZ + 999) / 1000)

`endif

// File: verilog/boot_lock_pkg.sv
// types shared by the start-up and debug lock logic
package boot_lock_pkg;

    typedef enum logic [1:0] {
        GEAR_DIV1,
        GEAR_DIV2,
        GEAR_DIV4,
        GEAR_DIV8
    } gear_t;

    typedef enum logic [1:0] {
        MODE_SINGLE_CHIP,
        MODE_SINGLE_BOOT,
        MODE_WRITER
    } op_mode_t;

    typedef enum logic [1:0] {
        ST_POR,
        ST_HOLD,
        ST_RUN
    } rst_state_t;

endpackage

// File: verilog/boot_mode_reset_debug_lock.sv
// start-up mode latch, reset timing, flash protect hold and debug probe lock
`timescale 1ns/10ps
`include "boot_lock_defs.svh"

module boot_mode_reset_debug_lock
    import boot_lock_pkg::*;
#(
    parameter int POR_CYCLES = `POR_CYCLES,
    parameter int CNT_W      = 13
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ext_reset_n_i,
    input  wire logic        width_strap_0_i,
    input  wire logic        width_strap_1_i,
    input  wire logic        startup_src_i,
    input  wire logic        flash_busy_i,
    input  wire logic [3:0]  area_stored_i,
    input  wire logic        probe_req_i,
    input  wire logic        probe_read_req_i,
    input  wire logic [31:0] paddr_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic             cpu_run_o,
    output logic             mode_single_chip_o,
    output logic             mode_single_boot_o,
    output logic             mode_writer_o,
    output logic [1:0]       clock_gear_o,
    output logic [3:0]       area_protect_o,
    output logic             probe_enable_o,
    output logic             probe_grant_o,
    output logic             probe_read_grant_o,
    output logic             probe_read_refused_o
);

    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    localparam int MAX_CNT = (2 ** CNT_W) - 1;
    if (POR_CYCLES < 1 || POR_CYCLES > MAX_CNT || `FLASH_RST_CYCLES > MAX_CNT) begin : g_bad
        $error("counter too narrow for reset durations");
    end

    localparam logic [CNT_W-1:0] POR_CNT   = CNT_W'(POR_CYCLES);
    localparam logic [CNT_W-1:0] NORM_CNT  = CNT_W'(`NORMAL_RST_CLKS);
    localparam logic [CNT_W-1:0] FLASH_CNT = CNT_W'(`FLASH_RST_CYCLES);
    localparam logic [CNT_W-1:0] SAT_CNT   = CNT_W'(MAX_CNT);

    // ----------------------------------------
    // functions
    // ----------------------------------------
    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        sat_inc = (v == SAT_CNT) ? v : v + 1'b1;
    endfunction

    function automatic logic is_lock_reg(input logic [31:0] a);
        is_lock_reg = (a == `LOCK_MODE_ADDR) || (a == `LOCK_KEY_ADDR);
    endfunction

    function automatic logic is_mapped(input logic [31:0] a);
        is_mapped = is_lock_reg(a) || (a == `FLASH_STAT_ADDR) || (a == `GEAR_STAT_ADDR);
    endfunction

    // partial writes to the lock registers are refused with an error
    function automatic logic bad_access(input logic [31:0] a, input logic [3:0] s,
                                        input logic w);
        bad_access = !is_mapped(a) || (w && is_lock_reg(a) && (s != `FULL_STRB));
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [3:0] pin_meta_reg;
    logic [3:0] pin_sync_reg;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_meta_reg <= 4'h0;
            pin_sync_reg <= 4'h0;
        end else begin
            pin_meta_reg <= {ext_reset_n_i, width_strap_1_i, width_strap_0_i, startup_src_i};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    logic pin_reset_n;
    logic strap_w0;
    logic strap_w1;
    logic strap_src;
    assign {pin_reset_n, strap_w1, strap_w0, strap_src} = pin_sync_reg;

    // ----------------------------------------
    // strap decode
    // ----------------------------------------
    op_mode_t strap_mode;
    always_comb begin
        if (strap_w0 && strap_w1 && strap_src) begin
            strap_mode = MODE_SINGLE_CHIP;
        end else if (strap_w0 && strap_w1) begin
            strap_mode = MODE_SINGLE_BOOT;
        end else begin
            strap_mode = MODE_WRITER;
        end
    end

    // ----------------------------------------
    // reset pin low-time counter
    // ----------------------------------------
    logic [CNT_W-1:0] low_cnt_reg;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            low_cnt_reg <= '0;
        end else if (pin_reset_n) begin
            low_cnt_reg <= '0;
        end else begin
            low_cnt_reg <= sat_inc(low_cnt_reg);
        end
    end

    // a reset pulse during programming must be longer than a plain one
    logic [CNT_W-1:0] run_min;
    assign run_min = flash_busy_i ? FLASH_CNT : NORM_CNT;

    // ----------------------------------------
    // reset sequencer
    // ----------------------------------------
    rst_state_t state_reg;
    rst_state_t state_next;
    op_mode_t   mode_reg;
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_POR: begin
                // early release is ignored until the power-on time is met
                if (pin_reset_n && low_cnt_reg >= POR_CNT) begin
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // writer mode never lets the cpu go
                if (pin_reset_n && mode_reg != MODE_WRITER) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                // shorter pulses are taken as glitches
                if (!pin_reset_n && low_cnt_reg >= run_min) begin
                    state_next = ST_HOLD;
                end
            end
            default: begin
                state_next = ST_POR;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= ST_POR;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------
    // mode latch
    // ----------------------------------------
    // straps are followed only while the pin holds reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_reg <= MODE_WRITER;
        end else if (state_reg != ST_RUN && !pin_reset_n) begin
            mode_reg <= strap_mode;
        end
    end

    // ----------------------------------------
    // clock gear
    // ----------------------------------------
    gear_t gear_reg;
    logic  acc_wr;
    logic  bus_ok;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            gear_reg <= GEAR_DIV8;
        end else if (state_reg != ST_RUN) begin
            gear_reg <= GEAR_DIV8;
        end else if (acc_wr && bus_ok && paddr_i == `GEAR_STAT_ADDR) begin
            gear_reg <= gear_t'(pwdata_i[`GEAR_MSB:`GEAR_LSB]);
        end
    end

    // ----------------------------------------
    // flash area protection view
    // ----------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            area_protect_o <= `AREA_LOCKED;
        end else if (state_reg == ST_POR) begin
            area_protect_o <= `AREA_LOCKED;
        end else begin
            area_protect_o <= area_stored_i;
        end
    end

    // ----------------------------------------
    // debug lock registers
    // ----------------------------------------
    logic probe_disable_reg;
    logic inhibit_reg;
    // only the power-on reset sets these, never the reset pin
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            probe_disable_reg <= `PROBE_DIS_RST;
        end else if (acc_wr && bus_ok && paddr_i == `LOCK_MODE_ADDR) begin
            probe_disable_reg <= pwdata_i[`PROBE_DIS_BIT];
        end
    end

    // two steps so a runaway write to one register cannot unlock
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            inhibit_reg <= `INHIBIT_RST;
        end else if (acc_wr && bus_ok && paddr_i == `LOCK_KEY_ADDR
                     && pwdata_i == `LOCK_KEY_VALUE) begin
            inhibit_reg <= probe_disable_reg;
        end
    end

    // ----------------------------------------
    // probe gating
    // ----------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            probe_enable_o       <= 1'b0;
            probe_grant_o        <= 1'b0;
            probe_read_grant_o   <= 1'b0;
            probe_read_refused_o <= 1'b0;
        end else begin
            probe_enable_o       <= !inhibit_reg;
            probe_grant_o        <= probe_req_i && !inhibit_reg;
            probe_read_grant_o   <= probe_read_req_i && !inhibit_reg;
            probe_read_refused_o <= probe_read_req_i && inhibit_reg;
        end
    end

    // ----------------------------------------
    // start-up outputs
    // ----------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cpu_run_o          <= 1'b0;
            mode_single_chip_o <= 1'b0;
            mode_single_boot_o <= 1'b0;
            mode_writer_o      <= 1'b0;
            clock_gear_o       <= GEAR_DIV8;
        end else begin
            cpu_run_o          <= (state_next == ST_RUN);
            mode_single_chip_o <= (mode_reg == MODE_SINGLE_CHIP);
            mode_single_boot_o <= (mode_reg == MODE_SINGLE_BOOT);
            mode_writer_o      <= (mode_reg == MODE_WRITER);
            clock_gear_o       <= gear_reg;
        end
    end

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    logic        setup;
    logic [31:0] rdata;
    assign setup  = psel_i && !penable_i;
    assign acc_wr = psel_i && penable_i && pready_o && pwrite_i;
    assign bus_ok = !pslverr_o;
    always_comb begin
        rdata = `ZERO_WORD;
        case (paddr_i)
            `LOCK_MODE_ADDR: begin
                rdata[`PROBE_DIS_BIT] = probe_disable_reg;
            end
            `FLASH_STAT_ADDR: begin
                rdata[`AREA_MSB:`AREA_LSB] = area_protect_o;
            end
            `GEAR_STAT_ADDR: begin
                rdata[`GEAR_MSB:`GEAR_LSB] = gear_reg;
                rdata[`MODE_MSB:`MODE_LSB] = mode_reg;
                rdata[`RUN_BIT]            = cpu_run_o;
            end
            default: begin
                rdata = `ZERO_WORD;
            end
        endcase
    end

    // one wait-free access phase: answer prepared during setup
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= `ZERO_WORD;
        end else begin
            pready_o  <= setup;
            pslverr_o <= setup && bad_access(paddr_i, pstrb_i, pwrite_i);
            prdata_o  <= (setup && !pwrite_i) ? rdata : `ZERO_WORD;
        end
    end

endmodule

// File: testbench/boot_mode_reset_debug_lock_properties.sv
// port assertions for the start-up mode and debug lock block
`timescale 1ns/10ps
module boot_lock_checker #(
    parameter int POR_CYCLES = 20
) (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       ext_reset_n_i,
    input wire logic       startup_src_i,
    input wire logic       probe_read_req_i,
    input wire logic       psel_i,
    input wire logic       penable_i,
    input wire logic       pready_o,
    input wire logic       cpu_run_o,
    input wire logic       mode_single_chip_o,
    input wire logic       mode_single_boot_o,
    input wire logic       mode_writer_o,
    input wire logic [1:0] clock_gear_o,
    input wire logic [3:0] area_protect_o,
    input wire logic       probe_enable_o,
    input wire logic       probe_grant_o,
    input wire logic       probe_read_grant_o,
    input wire logic       probe_read_refused_o
);
    // ----------------------------------------
    // helper counters
    // ----------------------------------------
    int por_cnt;
    int low_cnt;
    int last_low;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            por_cnt <= 0;
        end else if (por_cnt < POR_CYCLES) begin
            por_cnt <= por_cnt + 1;
        end
    end

    // raw pin runs: the block syncs the pin, so its own runs are never longer
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            low_cnt  <= 0;
            last_low <= 0;
        end else if (!ext_reset_n_i) begin
            low_cnt <= low_cnt + 1;
        end else begin
            low_cnt  <= 0;
            last_low <= (low_cnt > 0) ? low_cnt : last_low;
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_gear_eighth: assert property (
        !cpu_run_o && !$past(cpu_run_o) && !$past(cpu_run_o, 2) |-> clock_gear_o == 2'h3)
        else $error("gear not /8");
    a_area_locked: assert property (
        por_cnt < POR_CYCLES |-> area_protect_o == 4'hF) else $error("protect not held");
    a_run_mode: assert property (
        $rose(cpu_run_o) |-> ext_reset_n_i && !mode_writer_o
            && mode_single_chip_o == startup_src_i) else $error("bad start mode");
    a_writer_held: assert property (
        mode_writer_o && $past(mode_writer_o, 16) |-> !cpu_run_o) else $error("writer ran");
    a_mode_steady: assert property (
        cpu_run_o && $past(cpu_run_o) && ext_reset_n_i && $past(ext_reset_n_i, 3)
            |-> $stable({mode_single_chip_o, mode_single_boot_o})) else $error("mode moved");
    a_pready_once: assert property (
        psel_i && !penable_i |=> pready_o ##1 !pready_o) else $error("pready not a pulse");
    a_probe_blocked: assert property (
        !probe_enable_o |-> !probe_grant_o && !probe_read_grant_o) else $error("probe used");
    a_read_refused: assert property (
        $past(probe_read_req_i) && !probe_enable_o |-> probe_read_refused_o)
        else $error("read not refused");
    a_short_reset: assert property (
        $fell(cpu_run_o) |-> low_cnt >= 12 || last_low >= 12) else $error("short reset");
endmodule

bind boot_mode_reset_debug_lock boot_lock_checker #(.POR_CYCLES(POR_CYCLES)) i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .ext_reset_n_i(ext_reset_n_i),
    .startup_src_i(startup_src_i), .probe_read_req_i(probe_read_req_i), .psel_i(psel_i),
    .penable_i(penable_i), .pready_o(pready_o), .cpu_run_o(cpu_run_o),
    .mode_single_chip_o(mode_single_chip_o), .mode_single_boot_o(mode_single_boot_o),
    .mode_writer_o(mode_writer_o), .clock_gear_o(clock_gear_o),
    .area_protect_o(area_protect_o), .probe_enable_o(probe_enable_o),
    .probe_grant_o(probe_grant_o), .probe_read_grant_o(probe_read_grant_o),
    .probe_read_refused_o(probe_read_refused_o));

// File: testbench/board_side_model.sv
// board side: strap levels, reset pin, flash busy and probe requests
`timescale 1ns/10ps
module board_side_model (
    input  wire logic clk_i,
    output logic      ext_reset_n_o,
    output logic      width_strap_0_o,
    output logic      width_strap_1_o,
    output logic      startup_src_o,
    output logic      flash_busy_o,
    output logic      probe_req_o,
    output logic      probe_read_req_o
);
    initial begin
        ext_reset_n_o    = 1'b0;
        width_strap_0_o  = 1'b1;
        width_strap_1_o  = 1'b1;
        startup_src_o    = 1'b1;
        flash_busy_o     = 1'b0;
        probe_req_o      = 1'b0;
        probe_read_req_o = 1'b0;
    end

    // straps move only with the pin low; writer mode keeps the pin low
    task automatic pin_reset(input int cycles, input logic [2:0] straps, input logic busy);
        ext_reset_n_o <= 1'b0;
        flash_busy_o  <= busy;
        {width_strap_1_o, width_strap_0_o, startup_src_o} <= straps;
        repeat (cycles) @(posedge clk_i);
        if (straps[2:1] == 2'b11) begin
            ext_reset_n_o <= 1'b1;
        end
    endtask

    task automatic probe(input logic use_req, input logic read_req);
        probe_req_o      <= use_req;
        probe_read_req_o <= read_req;
    endtask
endmodule

// File: testbench/boot_mode_reset_debug_lock_tb.sv
// self-checking bench for the start-up mode, reset timing and debug lock block
`timescale 1ns/10ps
`include "boot_lock_defs.svh"
module boot_mode_reset_debug_lock_tb;
    localparam int POR_SIM = 20;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        ext_reset_n, strap_0, strap_1, src, busy, preq, prd;
    logic [3:0]  area_stored = 4'h6;
    logic [31:0] paddr = 32'h0000_0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [3:0]  pstrb = 4'hF;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, cpu_run, chip, boot, writer, pen, pgrant, prgrant, prref, er;
    logic [1:0]  gear;
    logic [3:0]  area;
    int          err_total = 0, tests_run = 0, cycles = 0;

    always #5 clk_i = ~clk_i;

    board_side_model i_board (.clk_i(clk_i), .ext_reset_n_o(ext_reset_n),
        .width_strap_0_o(strap_0), .width_strap_1_o(strap_1), .startup_src_o(src),
        .flash_busy_o(busy), .probe_req_o(preq), .probe_read_req_o(prd));
    boot_mode_reset_debug_lock #(.POR_CYCLES(POR_SIM)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .ext_reset_n_i(ext_reset_n), .width_strap_0_i(strap_0),
        .width_strap_1_i(strap_1), .startup_src_i(src), .flash_busy_i(busy),
        .area_stored_i(area_stored), .probe_req_i(preq), .probe_read_req_i(prd),
        .paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .cpu_run_o(cpu_run), .mode_single_chip_o(chip),
        .mode_single_boot_o(boot), .mode_writer_o(writer), .clock_gear_o(gear),
        .area_protect_o(area), .probe_enable_o(pen), .probe_grant_o(pgrant),
        .probe_read_grant_o(prgrant), .probe_read_refused_o(prref));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic report_and_stop();
        $display("tests_run=%0d err_total=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one idle edge after each transfer so register effects have landed
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_power_on();
        check(32'(area), 32'h0000_000F);
        check(32'(gear), 32'h0000_0003);
        apb(1'b0, `LOCK_MODE_ADDR, 32'h0000_0000, 4'hF);
        check(rd, 32'h0000_0001);
        apb(1'b0, `LOCK_KEY_ADDR, 32'h0000_0000, 4'hF);
        check(rd, 32'h0000_0000);
        apb(1'b0, 32'hFFFF_E520, 32'h0000_0000, 4'hF);
        check(32'(er), 32'h0000_0001);
        check(32'(cpu_run), 32'h0000_0000);
        i_board.pin_reset(POR_SIM + 10, 3'b111, 1'b0);
        repeat (8) @(posedge clk_i);
        check(32'({chip, cpu_run}), 32'h0000_0003);
        check(32'(area), 32'h0000_0006);
        area_stored <= 4'h9;
        // the protect view trails the stored bits by one edge
        @(posedge clk_i);
        apb(1'b0, `FLASH_STAT_ADDR, 32'h0000_0000, 4'hF);
        check(rd, 32'h0000_0009);
        $display("power-on and single chip start done");
    endtask

    task automatic t_unlock_relock();
        apb(1'b1, `LOCK_MODE_ADDR, 32'h0000_0000, 4'hF);
        apb(1'b1, `LOCK_KEY_ADDR, 32'h0000_00C4, 4'hF);
        apb(1'b1, `LOCK_MODE_ADDR, 32'h0000_0001, 4'h1);
        check(32'(er), 32'h0000_0001);
        apb(1'b0, `LOCK_MODE_ADDR, 32'h0000_0000, 4'hF);
        check(rd, 32'h0000_0000);
        i_board.probe(1'b1, 1'b1);
        repeat (3) @(posedge clk_i);
        check(32'({pen, pgrant, prref}), 32'h0000_0001);
        apb(1'b1, `LOCK_KEY_ADDR, `LOCK_KEY_VALUE, 4'hF);
        repeat (3) @(posedge clk_i);
        check(32'({pen, pgrant, prgrant, prref}), 32'h0000_000E);
        apb(1'b1, `LOCK_MODE_ADDR, 32'h0000_0001, 4'hF);
        repeat (3) @(posedge clk_i);
        check(32'(pen), 32'h0000_0001);
        apb(1'b1, `LOCK_KEY_ADDR, `LOCK_KEY_VALUE, 4'hF);
        repeat (3) @(posedge clk_i);
        check(32'({pen, pgrant, prgrant, prref}), 32'h0000_0001);
        i_board.probe(1'b0, 1'b0);
        $display("debug unlock and relock done");
    endtask

    task automatic t_pin_resets();
        apb(1'b1, `GEAR_STAT_ADDR, 32'h0000_0000, 4'hF);
        @(posedge clk_i);
        check(32'(gear), 32'h0000_0000);
        i_board.pin_reset(8, 3'b111, 1'b0);
        // look at every edge so a brief drop of the run output is caught
        repeat (8) begin
            @(posedge clk_i);
            check(32'(cpu_run), 32'h0000_0001);
        end
        i_board.pin_reset(20, 3'b111, 1'b1);
        repeat (8) begin
            @(posedge clk_i);
            check(32'(cpu_run), 32'h0000_0001);
        end
        apb(1'b1, `LOCK_MODE_ADDR, 32'h0000_0000, 4'hF);
        i_board.pin_reset(20, 3'b110, 1'b0);
        check(32'(cpu_run), 32'h0000_0000);
        repeat (8) @(posedge clk_i);
        check(32'({boot, chip, cpu_run, gear}), 32'h0000_0017);
        apb(1'b0, `LOCK_MODE_ADDR, 32'h0000_0000, 4'hF);
        check(32'({rd[0], pen}), 32'h0000_0000);
        i_board.pin_reset(30, 3'b000, 1'b0);
        check(32'({writer, cpu_run, gear}), 32'h0000_000B);
        $display("pin resets and modes done");
    endtask

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_power_on();
        t_unlock_relock();
        t_pin_resets();
        report_and_stop();
    end
endmodule
